//--- gpio_share_pkg.sv
/*
  Constants for the shared-pin port block: register byte offsets,
  field positions and reset values.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package gpio_share_pkg;
  localparam logic [7:0] OFS_FIRST_PINS = 8'h00;
  localparam logic [7:0] OFS_FIRST_LATCH = 8'h04;
  localparam logic [7:0] OFS_FIRST_DIR = 8'h08;
  localparam logic [7:0] OFS_SECOND_PINS = 8'h0C;
  localparam logic [7:0] OFS_SECOND_LATCH = 8'h10;
  localparam logic [7:0] OFS_SECOND_DIR = 8'h14;
  localparam logic [7:0] OFS_THIRD_REG = 8'h18;
  localparam logic [7:0] OFS_MEM_CTRL = 8'h1C;
  localparam logic [7:0] OFS_REF_CLOCK_OUT_CTRL = 8'h20;
  localparam int FIRST_PU_BIT = 7;
  localparam int SECOND_PU_BIT = 6;
  localparam int OTHER_PU_BIT = 5;
  localparam int EXT_BUS_DIS_BIT = 7;
  localparam int REF_CLOCK_OUT_EN_BIT = 0;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] THIRD_RESET = 8'h00;
  localparam logic MEM_DIS_RESET = 1'b1;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : gpio_share_pkg

//--- shared_bus_gpio_ports.sv
/*
  Two 8-bit general-purpose ports with pin sharing, APB register access.
  Assumes pins and peripheral signals synchronous to pclk; pad logic
  outside resolves out/oe/pull-up into the wire.
*/
`timescale 1ns/1ps
`default_nettype none
module shared_bus_gpio_ports (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pkg_80pin,
  input wire logic mcu_mode,
  input wire logic pwm_output_mux_cfg,
  input wire logic pwm2_output_mux_cfg,
  input wire logic pmp_mux_select,
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe,
  output logic [7:0] first_port_pullup,
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  output logic [7:0] second_port_pullup,
  input wire logic ext_bus_oe,
  input wire logic [15:0] ext_bus_out,
  output logic [15:0] ext_bus_in,
  input wire logic pmp_enable,
  input wire logic pmp_write_strobe,
  input wire logic pmp_read_strobe,
  input wire logic pmp_data_oe,
  input wire logic [7:0] pmp_data_out,
  output logic [7:0] pmp_data_in,
  input wire logic serial_clk_enable,
  input wire logic twowire_mode,
  input wire logic serial_clk_out,
  output logic serial_clock_pin_in,
  output logic twowire_clock_pin_in,
  output logic serial_slave_select,
  input wire logic [1:0] pwm1_bc_en,
  input wire logic [1:0] pwm1_bc_val,
  input wire logic [1:0] pwm3_bc_en,
  input wire logic [1:0] pwm3_bc_val,
  input wire logic [2:0] pwm2_bcd_en,
  input wire logic [2:0] pwm2_bcd_val,
  input wire logic pwm2_a_en,
  input wire logic pwm2_a_val,
  output logic [3:0] alternate_pwm_port_out,
  output logic [3:0] alternate_pwm_port_oe
);

  typedef struct packed {
    logic [7:0] lat1;
    logic [7:0] dir1;
    logic [7:0] lat2;
    logic [7:0] dir2;
    logic [7:0] third;
    logic mem_dis;
    logic ref_clock_out_en;
    logic ref_clock_out_tgl;
    logic [7:0] pin1;
    logic [7:0] pin2;
    logic [7:0] out1;
    logic [7:0] oe1;
    logic [7:0] pu1;
    logic [7:0] out2;
    logic [7:0] oe2;
    logic [7:0] pu2;
    logic [3:0] alt_out;
    logic [3:0] alt_oe;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic bus_on;
  logic pwm_remap;
  logic wr_en;
  logic [7:0] pwm_en2;
  logic [7:0] pwm_val2;

  ////////////////////////////////////////////////////////////////////////
  // pin function selection

  always_comb begin
    bus_on = pkg_80pin & ~st_q.mem_dis;
    pwm_remap = pkg_80pin & ~pwm_output_mux_cfg;
    pwm_en2 = 8'h00;
    pwm_val2 = 8'h00;
    pwm_en2[7] = mcu_mode & ~pwm2_output_mux_cfg & pwm2_a_en;
    pwm_val2[7] = pwm2_a_val;
    pwm_en2[6:5] = pwm_remap ? 2'h0 : pwm1_bc_en;
    pwm_val2[6:5] = pwm1_bc_val;
    pwm_en2[4:3] = pwm_remap ? 2'h0 : pwm3_bc_en;
    pwm_val2[4:3] = pwm3_bc_val;
    pwm_en2[2:0] = pwm2_bcd_en;
    pwm_val2[2:0] = pwm2_bcd_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    wr_en = psel & penable & pwrite & st_q.ack;
    // sampled pin levels; inputs are already synchronous to pclk
    st_d.pin1 = first_port_pins_in;
    st_d.pin2 = second_port_pins_in;
    // divide by two of the system clock while ref_clock_out_en is set, held low otherwise
    st_d.ref_clock_out_tgl = st_q.ref_clock_out_en ? ~st_q.ref_clock_out_tgl : 1'b0;

    // one wait state so that read data comes straight from a flop
    st_d.ack = psel & penable & ~st_q.ack;
    st_d.err = 1'b0;
    if (psel & penable & ~st_q.ack) begin
      st_d.rdata = gpio_share_pkg::READ_UNMAPPED;
      case (paddr)
        gpio_share_pkg::OFS_FIRST_PINS: st_d.rdata[7:0] = st_q.pin1;
        gpio_share_pkg::OFS_FIRST_LATCH: st_d.rdata[7:0] = st_q.lat1;
        gpio_share_pkg::OFS_FIRST_DIR: st_d.rdata[7:0] = st_q.dir1;
        gpio_share_pkg::OFS_SECOND_PINS: st_d.rdata[7:0] = st_q.pin2;
        gpio_share_pkg::OFS_SECOND_LATCH: st_d.rdata[7:0] = st_q.lat2;
        gpio_share_pkg::OFS_SECOND_DIR: st_d.rdata[7:0] = st_q.dir2;
        gpio_share_pkg::OFS_THIRD_REG: st_d.rdata[7:0] = st_q.third;
        gpio_share_pkg::OFS_MEM_CTRL: st_d.rdata[gpio_share_pkg::EXT_BUS_DIS_BIT] = st_q.mem_dis;
        gpio_share_pkg::OFS_REF_CLOCK_OUT_CTRL: st_d.rdata[gpio_share_pkg::REF_CLOCK_OUT_EN_BIT] = st_q.ref_clock_out_en;
        default: st_d.err = 1'b1;
      endcase
    end

    if (wr_en) begin
      case (paddr)
        gpio_share_pkg::OFS_FIRST_PINS: st_d.lat1 = pwdata[7:0];
        gpio_share_pkg::OFS_FIRST_LATCH: st_d.lat1 = pwdata[7:0];
        gpio_share_pkg::OFS_FIRST_DIR: st_d.dir1 = pwdata[7:0];
        gpio_share_pkg::OFS_SECOND_PINS: st_d.lat2 = pwdata[7:0];
        gpio_share_pkg::OFS_SECOND_LATCH: st_d.lat2 = pwdata[7:0];
        gpio_share_pkg::OFS_SECOND_DIR: st_d.dir2 = pwdata[7:0];
        gpio_share_pkg::OFS_THIRD_REG: begin
          st_d.third = pwdata[7:0];
          // no such pull-up control on the small package
          st_d.third[gpio_share_pkg::OTHER_PU_BIT] =
            pwdata[gpio_share_pkg::OTHER_PU_BIT] & pkg_80pin;
        end
        gpio_share_pkg::OFS_MEM_CTRL:
          st_d.mem_dis = pwdata[gpio_share_pkg::EXT_BUS_DIS_BIT];
        gpio_share_pkg::OFS_REF_CLOCK_OUT_CTRL: st_d.ref_clock_out_en = pwdata[gpio_share_pkg::REF_CLOCK_OUT_EN_BIT];
        default: st_d.err = 1'b1;
      endcase
    end
    if (!pkg_80pin) begin
      st_d.third[gpio_share_pkg::OTHER_PU_BIT] = 1'b0;
    end

    // second port: bus, then pwm, then pmp strobes, then ref clock, then latch
    for (int i = 0; i < 8; i++) begin
      st_d.out2[i] = st_q.lat2[i];
      st_d.oe2[i] = ~st_q.dir2[i];
      if (bus_on) begin
        st_d.out2[i] = ext_bus_out[8 + i];
        st_d.oe2[i] = ext_bus_oe;
      end else if (pwm_en2[i] & ~st_q.dir2[i]) begin
        st_d.out2[i] = pwm_val2[i];
        st_d.oe2[i] = 1'b1;
      end else if (i < 2 && pmp_enable && !pmp_mux_select) begin
        st_d.out2[i] = (i == 1) ? pmp_write_strobe : pmp_read_strobe;
        st_d.oe2[i] = 1'b1;
      end else if (i == 3 && st_q.ref_clock_out_en) begin
        st_d.out2[i] = st_q.ref_clock_out_tgl;
        st_d.oe2[i] = 1'b1;
      end
      // pull-up only on a pin that is not driven by anything
      st_d.pu2[i] = st_q.third[gpio_share_pkg::SECOND_PU_BIT] & ~st_d.oe2[i];
    end

    // first port: bus, then pmp data, then serial clock, then latch
    for (int i = 0; i < 8; i++) begin
      st_d.out1[i] = st_q.lat1[i];
      st_d.oe1[i] = ~st_q.dir1[i];
      if (bus_on) begin
        st_d.out1[i] = ext_bus_out[i];
        st_d.oe1[i] = ext_bus_oe;
      end else if (pmp_mux_select && pmp_enable) begin
        st_d.out1[i] = pmp_data_out[i];
        st_d.oe1[i] = pmp_data_oe;
      end else if (i == 6 && serial_clk_enable) begin
        st_d.out1[i] = serial_clk_out;
        st_d.oe1[i] = ~st_q.dir1[i];
      end else if (i == 7 && serial_clk_enable) begin
        st_d.oe1[i] = 1'b0;
      end
      st_d.pu1[i] = st_q.third[gpio_share_pkg::FIRST_PU_BIT] & ~st_d.oe1[i];
    end

    // pwm units 1 and 3 B/C moved to the other port
    st_d.alt_out = {pwm1_bc_val, pwm3_bc_val};
    st_d.alt_oe = pwm_remap ? {pwm1_bc_en, pwm3_bc_en} : 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.lat1 <= gpio_share_pkg::LATCH_RESET;
      st_q.lat2 <= gpio_share_pkg::LATCH_RESET;
      st_q.dir1 <= gpio_share_pkg::DIR_RESET;
      st_q.dir2 <= gpio_share_pkg::DIR_RESET;
      st_q.third <= gpio_share_pkg::THIRD_RESET;
      st_q.mem_dis <= gpio_share_pkg::MEM_DIS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = st_q.rdata;
  assign pready = st_q.ack;
  assign pslverr = st_q.ack & st_q.err;
  assign first_port_pins_out = st_q.out1;
  assign first_port_pins_oe = st_q.oe1;
  assign first_port_pullup = st_q.pu1;
  assign second_port_pins_out = st_q.out2;
  assign second_port_pins_oe = st_q.oe2;
  assign second_port_pullup = st_q.pu2;
  assign alternate_pwm_port_out = st_q.alt_out;
  assign alternate_pwm_port_oe = st_q.alt_oe;
  assign ext_bus_in = {st_q.pin2, st_q.pin1};
  assign pmp_data_in = pmp_mux_select ? st_q.pin1 : 8'h00;
  assign serial_clock_pin_in = ~twowire_mode & st_q.pin1[6];
  assign twowire_clock_pin_in = twowire_mode & st_q.pin1[6];
  assign serial_slave_select = st_q.pin1[7];

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BUS_OVERRIDE: assert property (
    bus_on && ext_bus_oe |=> second_port_pins_oe == 8'hFF
      && second_port_pins_out == $past(ext_bus_out[15:8]))
    else $error("external bus did not own second port");

  AST_PORT_DIR: assert property (
    !bus_on && pwm_en2 == 8'h00 && !pmp_enable && !st_q.ref_clock_out_en
      |=> second_port_pins_oe == ~$past(st_q.dir2))
    else $error("second port direction not followed");

  AST_PU_OUTPUT: assert property (
    ##1 (second_port_pullup & second_port_pins_oe) == 8'h00)
    else $error("pull-up left on a driven pin");

  AST_PU_GLOBAL: assert property (
    !st_q.third[gpio_share_pkg::SECOND_PU_BIT] |=> second_port_pullup == 8'h00)
    else $error("second port pull-up not disabled");

  AST_PMP_STROBES: assert property (
    !bus_on && !pmp_mux_select && pmp_enable && pwm_en2[1:0] == 2'h0
      |=> second_port_pins_out[1:0] == $past({pmp_write_strobe, pmp_read_strobe}))
    else $error("pmp strobes missing on second port");

  AST_PMP_DATA: assert property (
    !pmp_mux_select |-> pmp_data_in == 8'h00)
    else $error("pmp data read while not selected");

  AST_SERIAL_CLK: assert property (
    !bus_on && !(pmp_mux_select && pmp_enable) && serial_clk_enable && !st_q.dir1[6]
      |=> first_port_pins_oe[6] && first_port_pins_out[6] == $past(serial_clk_out))
    else $error("serial clock not driven on bit 6");

  AST_REF_CLOCK_OUT: assert property (
    !bus_on && pwm_en2[3] == 1'b0 && st_q.ref_clock_out_en
      ##1 (!bus_on && pwm_en2[3] == 1'b0 && st_q.ref_clock_out_en)
      |=> second_port_pins_out[3] != $past(second_port_pins_out[3]))
    else $error("reference clock not toggling");

  AST_OTHER_PU_64: assert property (
    !pkg_80pin ##1 !pkg_80pin |-> !st_q.third[gpio_share_pkg::OTHER_PU_BIT])
    else $error("other-port pull-up set on small package");

  AST_APB_ACK: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  // bit 7 falls back to its latch unless the alternate pwm pin is chosen
  AST_PWM2_ALT: assert property (
    !bus_on && pwm2_a_en && !st_q.dir2[7] && !(mcu_mode && !pwm2_output_mux_cfg)
      |=> second_port_pins_out[7] == $past(st_q.lat2[7]))
    else $error("pwm unit2 output A on bit 7 outside its mode");

  AST_SSEL_INPUT: assert property (
    !bus_on && !(pmp_mux_select && pmp_enable) && serial_clk_enable
      |=> !first_port_pins_oe[7])
    else $error("slave-select pin driven");

  AST_PU1_GLOBAL: assert property (
    !st_q.third[gpio_share_pkg::FIRST_PU_BIT] |=> first_port_pullup == 8'h00)
    else $error("first port pull-up not disabled");

  COV_WRITE: cover property (wr_en);
  COV_BUS: cover property (bus_on && ext_bus_oe);
  COV_REMAP: cover property (pwm_remap && pwm1_bc_en != 2'h0);
  COV_UNMAPPED: cover property (pslverr);
  COV_REF_CLOCK_OUT: cover property (st_q.ref_clock_out_en && second_port_pins_oe[3]);

endmodule : shared_bus_gpio_ports
`default_nettype wire

//--- shared_bus_gpio_ports_tb_top.sv
/*
  Self-checking bench for the shared-pin port block: APB master tasks and
  hand-written scenarios.
  Assumes pads are absent; the bench drives the sampled pin levels itself.
*/
`timescale 1ns/1ps
`default_nettype none
module shared_bus_gpio_ports_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv, v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pkg_80pin, mcu_mode, pwm_output_mux_cfg, pwm2_output_mux_cfg, pmp_mux_select;
  logic [7:0] first_port_pins_in, first_port_pins_out, first_port_pins_oe, first_port_pullup;
  logic [7:0] second_port_pins_in, second_port_pins_out, second_port_pins_oe;
  logic [7:0] second_port_pullup, pmp_data_out, pmp_data_in;
  logic ext_bus_oe, pmp_enable, pmp_write_strobe, pmp_read_strobe, pmp_data_oe;
  logic [15:0] ext_bus_out, ext_bus_in;
  logic serial_clk_enable, twowire_mode, serial_clk_out, serial_clock_pin_in;
  logic twowire_clock_pin_in, serial_slave_select, pwm2_a_en, pwm2_a_val;
  logic [1:0] pwm1_bc_en, pwm1_bc_val, pwm3_bc_en, pwm3_bc_val;
  logic [2:0] pwm2_bcd_en, pwm2_bcd_val;
  logic [3:0] alternate_pwm_port_out, alternate_pwm_port_oe;
  int miscompares, comparisons;
  shared_bus_gpio_ports dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pkg_80pin, .mcu_mode, .pwm_output_mux_cfg,
    .pwm2_output_mux_cfg, .pmp_mux_select, .first_port_pins_in, .first_port_pins_out,
    .first_port_pins_oe, .first_port_pullup, .second_port_pins_in, .second_port_pins_out,
    .second_port_pins_oe, .second_port_pullup, .ext_bus_oe, .ext_bus_out, .ext_bus_in,
    .pmp_enable, .pmp_write_strobe, .pmp_read_strobe, .pmp_data_oe, .pmp_data_out,
    .pmp_data_in, .serial_clk_enable, .twowire_mode, .serial_clk_out, .serial_clock_pin_in,
    .twowire_clock_pin_in, .serial_slave_select, .pwm1_bc_en, .pwm1_bc_val, .pwm3_bc_en,
    .pwm3_bc_val, .pwm2_bcd_en, .pwm2_bcd_val, .pwm2_a_en, .pwm2_a_val,
    .alternate_pwm_port_out, .alternate_pwm_port_oe);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // no fixed wait state is assumed; the loop bound only catches a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, exp);
  endtask : rd
  // pin outputs lag their causes by a register stage; read at the edge,
  // before it updates them, so that stimulus stays on the rising edge
  task automatic st;
    repeat (3) @(posedge pclk);
  endtask : st
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {mcu_mode, pmp_mux_select, ext_bus_oe, ext_bus_out, pmp_enable} = '0;
    {pmp_write_strobe, pmp_read_strobe, pmp_data_oe, pmp_data_out, serial_clk_enable} = '0;
    {twowire_mode, serial_clk_out, pwm1_bc_en, pwm1_bc_val, pwm3_bc_en, pwm3_bc_val} = '0;
    {pwm2_bcd_en, pwm2_bcd_val, pwm2_a_en, pwm2_a_val, first_port_pins_in} = '0;
    {pkg_80pin, pwm_output_mux_cfg, pwm2_output_mux_cfg} = 3'h7;
    second_port_pins_in = 8'h00;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(gpio_share_pkg::OFS_SECOND_DIR, 32'hFF, "dir2");
    rd(gpio_share_pkg::OFS_FIRST_DIR, 32'hFF, "dir1");
    rd(gpio_share_pkg::OFS_THIRD_REG, 32'h00, "third");
    rd(gpio_share_pkg::OFS_MEM_CTRL, 32'h80, "memctl");
    chk("oe2", second_port_pins_oe, 32'h0);
    chk("pu2", second_port_pullup, 32'h0);
    $display("reset test done");
    wr(gpio_share_pkg::OFS_SECOND_DIR, 8'hF0);
    wr(gpio_share_pkg::OFS_SECOND_PINS, 8'h5A);
    rd(gpio_share_pkg::OFS_SECOND_LATCH, 32'h5A, "latch2");
    wr(gpio_share_pkg::OFS_FIRST_LATCH, 8'h81);
    wr(gpio_share_pkg::OFS_FIRST_DIR, 8'h7E);
    @(posedge pclk);
    second_port_pins_in <= 8'h3C;
    first_port_pins_in <= 8'h96;
    st;
    rd(gpio_share_pkg::OFS_SECOND_PINS, 32'h3C, "pins2");
    rd(gpio_share_pkg::OFS_FIRST_PINS, 32'h96, "pins1");
    chk("oe2", second_port_pins_oe, 32'h0F);
    chk("out2", second_port_pins_out[3:0], 32'hA);
    chk("oe1", first_port_pins_oe, 32'h81);
    $display("latch test done");
    wr(gpio_share_pkg::OFS_THIRD_REG, 8'hC0);
    st;
    chk("pu2", second_port_pullup, 32'hF0);
    chk("pu1", first_port_pullup, 32'h7E);
    wr(gpio_share_pkg::OFS_THIRD_REG, 8'h80);
    st;
    chk("pu2", second_port_pullup, 32'h00);
    wr(gpio_share_pkg::OFS_THIRD_REG, 8'h40);
    st;
    chk("pu1", first_port_pullup, 32'h00);
    chk("pu2", second_port_pullup, 32'hF0);
    @(posedge pclk);
    pkg_80pin <= 1'b0;
    wr(gpio_share_pkg::OFS_THIRD_REG, 8'h7F);
    rd(gpio_share_pkg::OFS_THIRD_REG, 32'h5F, "third64");
    pkg_80pin <= 1'b1;
    wr(gpio_share_pkg::OFS_THIRD_REG, 8'h7F);
    rd(gpio_share_pkg::OFS_THIRD_REG, 32'h7F, "third80");
    $display("pull-up test done");
    // bus must win even against an active parallel port on the same pins
    {ext_bus_oe, pmp_enable, pmp_mux_select, pmp_data_oe} <= 4'hF;
    ext_bus_out <= 16'h5AC3;
    pmp_data_out <= 8'hA5;
    wr(gpio_share_pkg::OFS_MEM_CTRL, 8'h00);
    st;
    chk("out2", second_port_pins_out, 32'h5A);
    chk("oe2", second_port_pins_oe, 32'hFF);
    chk("pu2", second_port_pullup, 32'h00);
    chk("out1", first_port_pins_out, 32'hC3);
    chk("oe1", first_port_pins_oe, 32'hFF);
    chk("busin", ext_bus_in, 32'h3C96);
    @(posedge pclk);
    pkg_80pin <= 1'b0;
    pmp_enable <= 1'b0;
    st;
    chk("oe1", first_port_pins_oe, 32'h81);
    @(posedge pclk);
    pkg_80pin <= 1'b1;
    wr(gpio_share_pkg::OFS_MEM_CTRL, 8'h80);
    st;
    chk("oe2", second_port_pins_oe, 32'h0F);
    $display("bus test done");
    @(posedge pclk);
    {pmp_enable, pmp_mux_select, pmp_write_strobe, pmp_read_strobe} <= 4'b1001;
    st;
    chk("strobes", second_port_pins_out[1:0], 32'h1);
    chk("oe1", first_port_pins_oe, 32'h81);
    chk("pmpin", pmp_data_in, 32'h00);
    @(posedge pclk);
    pmp_mux_select <= 1'b1;
    st;
    chk("out2", second_port_pins_out[1:0], 32'h2);
    chk("out1", first_port_pins_out, 32'hA5);
    chk("oe1", first_port_pins_oe, 32'hFF);
    chk("pmpin", pmp_data_in, 32'h96);
    pmp_enable <= 1'b0;
    $display("parallel port test done");
    {serial_clk_enable, serial_clk_out} <= 2'b11;
    wr(gpio_share_pkg::OFS_FIRST_LATCH, 8'h00);
    wr(gpio_share_pkg::OFS_FIRST_DIR, 8'h3F);
    st;
    chk("sck", first_port_pins_out[6], 32'h1);
    chk("oe76", first_port_pins_oe[7:6], 32'h1);
    chk("ssel", serial_slave_select, 32'h1);
    {twowire_mode, serial_clk_out} <= 2'b10;
    wr(gpio_share_pkg::OFS_FIRST_LATCH, 8'h40);
    st;
    chk("scl", first_port_pins_out[6], 32'h0);
    first_port_pins_in <= 8'h40;
    wr(gpio_share_pkg::OFS_FIRST_DIR, 8'hFF);
    st;
    chk("oe6", first_port_pins_oe[6], 32'h0);
    chk("sclin", twowire_clock_pin_in, 32'h1);
    chk("sckin", serial_clock_pin_in, 32'h0);
    chk("ssel", serial_slave_select, 32'h0);
    twowire_mode <= 1'b0;
    st;
    chk("sckin", serial_clock_pin_in, 32'h1);
    chk("sclin", twowire_clock_pin_in, 32'h0);
    $display("serial test done");
    {pwm1_bc_en, pwm1_bc_val, pwm3_bc_en, pwm3_bc_val} <= 8'b1110_1101;
    {pwm2_bcd_en, pwm2_bcd_val, pwm2_a_en, pwm2_a_val} <= 8'b111_101_11;
    {mcu_mode, pwm2_output_mux_cfg} <= 2'b10;
    wr(gpio_share_pkg::OFS_SECOND_LATCH, 8'h00);
    wr(gpio_share_pkg::OFS_SECOND_DIR, 8'h00);
    st;
    chk("pwm2", second_port_pins_out, 32'hCD);
    mcu_mode <= 1'b0;
    st;
    chk("pwm2a", second_port_pins_out, 32'h4D);
    @(posedge pclk);
    {pwm_output_mux_cfg, pwm2_output_mux_cfg} <= 2'b01;
    st;
    chk("pwmalt", {alternate_pwm_port_oe, alternate_pwm_port_out}, 32'hF9);
    chk("pwm2", second_port_pins_out, 32'h05);
    @(posedge pclk);
    {pwm1_bc_en, pwm3_bc_en, pwm2_bcd_en, pwm2_a_en} <= '0;
    wr(gpio_share_pkg::OFS_REF_CLOCK_OUT_CTRL, 8'h01);
    st;
    v = second_port_pins_out[3];
    @(posedge pclk);
    chk("ref_clock_out", second_port_pins_out[3], {31'h0, ~v});
    chk("refooe", second_port_pins_oe[3], 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
    apb(1'b1, 8'h40, 32'hFF);
    chk("unmappedw", errv, 32'h1);
    $display("pwm and clock test done");
    print_verdict;
  end
  initial begin
    #200us;
    miscompares++;
    print_verdict;
  end
endmodule : shared_bus_gpio_ports_tb_top
`default_nettype wire
